// ---- ume_engine.sv ----
// Serial engine for mode 0 (shift register) and mode 1 (10-bit frame).
//
// Functional notes
// - Mode 0 shifts 8 bits LSB first.
// - Mode 0 rate is CPU clock over twelve.
// - Mode 0 write loads marker, sends later.
// - Shift clock low S3-S5, high otherwise.
// - Transmit shifts right at S6P2, zero fill.
// - Marker at output ends send, sets flag.
// - Receive preloads 11111110 when enabled.
// - Receive shift clock toggles S3P1, S6P1.
// - Receive shifts left with S5P2 sample.
// - Preload zero at top ends reception.
// - Frame: start, 8 data LSB first, stop.
// - Mode 1 bit timing from timer overflow; send starts at S1P1.
// - Baud doubling bit clears at reset.
// - Mode 1 send starts after counter rollover.
// - Start bit, then data, then shifts.
// - Final shift ends send, sets flag.
// - Falling edge resets counter, preloads 1FFH.
// - Two of three samples decide bit.
// - Start bit not zero means restart.
// - Nine-bit receive shift, left, ends.
// - Load only if flag clear, stop valid or filter off.
// - After frame, watch for next edge.
// - Rate is overflow over 32 or 16.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ume_engine
	import ume_pkg::*;
(
	input  wire logic       I_CLK,     // CPU clock.
	input  wire logic       I_RST,     // Synchronous reset, active high.
	input  wire logic [1:0] I_ADDR,    // Register address.
	input  wire logic [7:0] I_WDATA,   // Write data.
	input  wire logic       I_WR,      // Write strobe.
	input  wire logic       I_RD,      // Read strobe.
	output var  logic [7:0] O_RDATA,   // Read data, cycle after the strobe.
	input  wire logic       I_T1_OVF,  // Timer 1 overflow pulse.
	input  wire logic       I_RXD,     // Receive data pin, input side.
	output var  logic       O_RXD,     // Receive data pin, driven value.
	output var  logic       O_RXD_OE,  // Receive data pin, output enable.
	output var  logic       O_TXD,     // Transmit pin: frame or shift clock.
	output var  logic       O_SINT     // Serial interrupt request.
);
	// ==========================================================
	// Storage.
	logic [3:0] pos;           // Machine cycle position.
	logic [1:0] mode;          // Mode field.
	logic       filter;        // Multiprocessor filter bit.
	logic       rx_en;         // Receive enable bit.
	logic       ninth;         // Received stop bit.
	logic       tx_done;       // Transmit done flag.
	logic       rx_done;       // Receive done flag.
	logic       baud_double;   // Baud doubling bit.
	logic [7:0] serial_buffer; // Received byte.
	logic       rxd_meta;      // First synchroniser stage.
	logic       rxd_s;         // Synchronised receive pin.
	logic       rxd_prev;      // Pin value at the previous 16x tick.
	logic       pre;           // Overflow halving toggle.
	logic [3:0] cnt;           // Divide-by-16 counter.
	logic [8:0] tx_shift;      // Transmit shift register.
	logic       tx_pend;       // Transmission requested.
	logic       tx_go;         // Mode 1: rollover seen, start at S1P1.
	logic       send;          // Transmission active.
	logic       data_on;       // Mode 1: shift register drives the pin.
	logic       tx_last;       // Mode 0: final shift done.
	logic [8:0] rx_shift;      // Receive shift register.
	logic       rx0_act;       // Mode 0 reception active.
	logic       rx0_fin;       // Mode 0 final shift done.
	logic       m0_bit;        // Mode 0 pin sample from S5P2.
	logic       busy1;         // Mode 1 frame in progress.
	logic       first;         // Mode 1 still in the start bit.
	logic [SMP_COUNT-1:0] smp; // Mode 1 samples at states 7, 8, 9.

	// ==========================================================
	// Decoding.
	wire       m0       = (mode == MODE_SHIFT);
	wire       m1       = (mode == MODE_ASYNC);
	wire [3:0] pos_next = (pos == POS_LAST) ? POS_S1P1 : pos + 4'h1;
	wire       at_s1p1  = (pos == POS_S1P1);
	wire       at_s5p2  = (pos == POS_S5P2);
	wire       at_s6p2  = (pos == POS_S6P2);
	wire       wr_ctrl  = I_WR && (I_ADDR == REG_CTRL);
	wire       wr_buf   = I_WR && (I_ADDR == REG_BUF);
	wire       wr_pwr   = I_WR && (I_ADDR == REG_PWR);
	// A write while a transfer is requested or running is ignored.
	wire       tx_take  = wr_buf && !send && !tx_pend && !tx_go;
	// Doubling passes every overflow; otherwise every second one.
	wire       tick     = I_T1_OVF && (baud_double || pre);
	wire       rollover = tick && (cnt == DIV_LAST);
	wire       maj      = (smp[0] & smp[1]) | (smp[0] & smp[2]) | (smp[1] & smp[2]);
	wire       tx_end   = send && (tx_shift[8:1] == TX_MARK);
	wire       tx1_fin  = m1 && rollover && data_on && tx_end;
	wire       tx0_fin  = m0 && at_s1p1 && tx_last;
	wire       rx_edge  = m1 && rx_en && !busy1 && tick && rxd_prev && !rxd_s;
	wire       rx1_step = rollover && busy1;
	wire       rx1_fin  = rx1_step && !first && !rx_shift[8];
	wire       rx1_load = rx1_fin && !rx_done && (!filter || maj);
	wire       rx0_go   = m0 && rx_en && !rx_done && !rx0_act && !send && at_s6p2;
	wire       rx0_last = rx0_act && at_s6p2 && !rx_shift[7];
	wire       ti_set   = tx0_fin || tx1_fin;
	wire       ri_set   = (m0 && at_s1p1 && rx0_fin) || rx1_load;
	wire       clk_act  = send || rx0_act;
	wire       clk_low  = (pos_next >= POS_S3P1) && (pos_next <= POS_S5P2);
	// Shift clock window for the position now shown on the pin; checks only.
	wire       clk_low_now = (pos >= POS_S3P1) && (pos <= POS_S5P2);
	wire [7:0] fin_byte = m0 ? {rx_shift[6:0], m0_bit} : rx_shift[7:0];
	wire [7:0] rx_rev;

	// The shift register fills from the right, so the first bit ends on top.
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_rev
			assign rx_rev[gi] = fin_byte[7-gi];
		end
	endgenerate

	// ==========================================================
	// Machine cycle sequencer.
	ume_mcycle u_mcycle (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.o_pos (pos)
	);

	// ==========================================================
	// Pin synchroniser; only the second stage is ever looked at.
	always_ff @(posedge I_CLK) begin
		rxd_meta <= I_RXD;
		rxd_s    <= rxd_meta;
	end

	// ==========================================================
	// Control bits written by software.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			mode        <= MODE_RST;
			filter      <= 1'b0;
			rx_en       <= 1'b0;
			baud_double <= DOUBLE_RST;
		end else begin
			if (wr_ctrl) begin
				mode   <= I_WDATA[CTRL_MODE_HI:CTRL_MODE_LO];
				filter <= I_WDATA[CTRL_FILTER];
				rx_en  <= I_WDATA[CTRL_RXEN];
			end
			if (wr_pwr) begin
				baud_double <= I_WDATA[PWR_DOUBLE];
			end
		end
	end

	// Done flags: hardware sets, software writes either value; a hardware set wins.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			tx_done <= 1'b0;
			rx_done <= 1'b0;
		end else if (wr_ctrl) begin
			tx_done <= I_WDATA[CTRL_TXDONE] | ti_set;
			rx_done <= I_WDATA[CTRL_RXDONE] | ri_set;
		end else begin
			tx_done <= tx_done | ti_set;
			rx_done <= rx_done | ri_set;
		end
	end

	// Received byte and stop bit.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			serial_buffer <= 8'h00;
			ninth         <= 1'b0;
		end else if (rx0_last || rx1_load) begin
			serial_buffer <= rx_rev;
			if (rx1_load) begin
				ninth <= maj;
			end
		end
	end

	// ==========================================================
	// Bit-rate divider: overflow halving and divide-by-16 counter.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			pre      <= 1'b0;
			cnt      <= 4'h0;
			rxd_prev <= 1'b1;
		end else begin
			if (I_T1_OVF) begin
				pre <= ~pre;
			end
			if (tick) begin
				rxd_prev <= rxd_s;
			end
			// A start edge realigns the counter to the incoming bit times.
			if (rx_edge) begin
				cnt <= 4'h0;
			end else if (tick) begin
				cnt <= cnt + 4'h1;
			end
		end
	end

	// Three samples per bit time, one per entry.
	generate
		for (gi = 0; gi < SMP_COUNT; gi++) begin : g_smp
			always_ff @(posedge I_CLK) begin
				if (I_RST) begin
					smp[gi] <= 1'b1;
				end else if (tick && (cnt == SMP_FIRST + 4'(gi))) begin
					smp[gi] <= rxd_s;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Transmitter for both modes.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			tx_shift <= 9'h000;
			tx_pend  <= 1'b0;
			tx_go    <= 1'b0;
			send     <= 1'b0;
			data_on  <= 1'b0;
			tx_last  <= 1'b0;
		end else if (tx_take) begin
			tx_shift <= {1'b1, I_WDATA};
			tx_pend  <= 1'b1;
		end else if (m0) begin
			// The first bit goes out at the next S6P2 after the write, at most one machine cycle later.
			if (tx_pend && at_s6p2) begin
				send    <= 1'b1;
				tx_pend <= 1'b0;
			end else if (send && at_s6p2 && !tx_last) begin
				tx_shift <= {1'b0, tx_shift[8:1]};
				tx_last  <= tx_end;
			end else if (tx0_fin) begin
				send    <= 1'b0;
				tx_last <= 1'b0;
			end
		end else if (m1) begin
			if (tx_pend && rollover) begin
				tx_go   <= 1'b1;
				tx_pend <= 1'b0;
			end else if (tx_go && at_s1p1) begin
				tx_go   <= 1'b0;
				send    <= 1'b1;
				data_on <= 1'b0;
			end else if (send && rollover) begin
				// Start bit until the next rollover, then data, then shifts.
				if (!data_on) begin
					data_on <= 1'b1;
				end else begin
					tx_shift <= {1'b0, tx_shift[8:1]};
					if (tx_end) begin
						send    <= 1'b0;
						data_on <= 1'b0;
					end
				end
			end
		end
	end

	// ==========================================================
	// Receiver for both modes, sharing one shift register.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			rx_shift <= M1_RX_LOAD;
			rx0_act  <= 1'b0;
			rx0_fin  <= 1'b0;
			m0_bit   <= 1'b1;
			busy1    <= 1'b0;
			first    <= 1'b0;
		end else if (m0) begin
			busy1 <= 1'b0;
			if (at_s5p2) begin
				m0_bit <= rxd_s;
			end
			if (rx0_go) begin
				rx_shift <= M0_RX_LOAD;
				rx0_act  <= 1'b1;
			end else if (rx0_act && at_s6p2 && !rx0_fin) begin
				rx_shift <= {rx_shift[7:0], m0_bit};
				rx0_fin  <= rx0_last;
			end else if (rx0_fin && at_s1p1) begin
				rx0_act <= 1'b0;
				rx0_fin <= 1'b0;
			end
		end else begin
			rx0_act <= 1'b0;
			rx0_fin <= 1'b0;
			if (rx_edge) begin
				rx_shift <= M1_RX_LOAD;
				busy1    <= 1'b1;
				first    <= 1'b1;
			end else if (rx1_step) begin
				if (first && maj) begin
					busy1 <= 1'b0;
				end else if (rx1_fin) begin
					busy1 <= 1'b0;
				end else begin
					rx_shift <= {rx_shift[7:0], maj};
					first    <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Pins. Registered so that every output comes from a flip-flop.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_TXD    <= 1'b1;
			O_RXD    <= 1'b1;
			O_RXD_OE <= 1'b0;
		end else begin
			O_RXD    <= tx_shift[0];
			O_RXD_OE <= m0 && send;
			if (m0) begin
				// The shift clock rate is fixed by the machine cycle alone.
				O_TXD <= !(clk_act && clk_low);
			end else if (m1 && send) begin
				O_TXD <= data_on ? tx_shift[0] : 1'b0;
			end else begin
				O_TXD <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Register reads and interrupt request.
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_RDATA <= 8'h00;
			O_SINT  <= 1'b0;
		end else begin
			O_SINT <= tx_done || rx_done;
			if (I_RD && (I_ADDR == REG_CTRL)) begin
				O_RDATA <= {mode, filter, rx_en, 1'b0, ninth, tx_done, rx_done};
			end else if (I_RD && (I_ADDR == REG_BUF)) begin
				O_RDATA <= serial_buffer;
			end else if (I_RD && (I_ADDR == REG_PWR)) begin
				O_RDATA <= {baud_double, 7'h00};
			end else begin
				O_RDATA <= 8'h00;
			end
		end
	end

	// ==========================================================
	// Checks.
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	sequence s_go1;
		m1 && tx_go && at_s1p1 && !tx_take;
	endsequence

	sequence s_start_low;
		send ##1 !O_TXD;
	endsequence

	rst_double_a: assert property (disable iff (1'b0) I_RST |=> !baud_double)
		else $error("doubling bit not cleared by reset");
	clk_low_a: assert property ((m0 && $past(clk_act) && $past(m0) && clk_low_now) |-> !O_TXD)
		else $error("shift clock high in S3 to S5");
	clk_high_a: assert property ((m0 && $past(clk_act) && $past(m0) && !clk_low_now) |-> O_TXD)
		else $error("shift clock low in S6 to S2");
	rx0_load_a: assert property (rx0_go |=> rx0_act && rx_shift[7:0] == 8'hFE)
		else $error("mode 0 receive preload wrong");
	edge_load_a: assert property (rx_edge |=> cnt == 4'h0 && rx_shift == 9'h1FF && busy1)
		else $error("start edge did not reset receive");
	false_start_a: assert property ((rx1_step && first && maj) |=> !busy1)
		else $error("false start not rejected");
	maj_shift_a: assert property ((m1 && rx1_step && !rx1_fin && !(first && maj)) |=> rx_shift[0] == $past(maj))
		else $error("majority bit not shifted in");
	full_keep_a: assert property ((rx1_fin && rx_done) |=> $stable(serial_buffer))
		else $error("frame loaded while flag set");
	tx_start_a: assert property (s_go1 |=> s_start_low)
		else $error("start bit not driven");
	// Software may write the flag to one itself, so only hardware sets are judged.
	tx_flag_a: assert property (($rose(tx_done) && !$past(wr_ctrl)) |-> $fell(send))
		else $error("transmit flag without end of send");
	irq_a: assert property ((tx_done || rx_done) |=> O_SINT)
		else $error("interrupt request missing");
endmodule
`default_nettype wire

// ---- ume_pkg.sv ----
// Shared constants for the mode 0 / mode 1 serial engine.
`default_nettype none
package ume_pkg;
	// ==========================================================
	// Register map on the plain register port.
	localparam logic [1:0] REG_CTRL = 2'h0;  // Serial control register.
	localparam logic [1:0] REG_BUF  = 2'h1;  // Serial buffer.
	localparam logic [1:0] REG_PWR  = 2'h2;  // Power control register.

	// ==========================================================
	// Field positions in the serial control register.
	localparam int CTRL_MODE_HI = 7;  // Mode field, upper bit.
	localparam int CTRL_MODE_LO = 6;  // Mode field, lower bit.
	localparam int CTRL_FILTER  = 5;  // Multiprocessor filter bit.
	localparam int CTRL_RXEN    = 4;  // Receive enable bit.
	localparam int CTRL_NINTH   = 2;  // Received ninth (stop) bit.
	localparam int CTRL_TXDONE  = 1;  // Transmit done flag.
	localparam int CTRL_RXDONE  = 0;  // Receive done flag.
	localparam int PWR_DOUBLE   = 7;  // Baud doubling bit in power control.

	// ==========================================================
	// Reset values and mode encodings.
	localparam logic [1:0] MODE_SHIFT = 2'h0;      // Mode 0, synchronous shift.
	localparam logic [1:0] MODE_ASYNC = 2'h1;      // Mode 1, 10-bit frame.
	localparam logic [1:0] MODE_RST   = 2'h0;      // Mode after reset.
	localparam logic       DOUBLE_RST = 1'b0;      // Undoubled rate after reset.
	localparam logic [8:0] M0_RX_LOAD = 9'h0FE;    // Mode 0 receive preload.
	localparam logic [8:0] M1_RX_LOAD = 9'h1FF;    // Mode 1 receive preload.
	localparam logic [7:0] TX_MARK    = 8'h01;     // Marker next to the output bit.

	// ==========================================================
	// Machine cycle positions: state S1..S6 times two phases.
	localparam logic [3:0] POS_S1P1 = 4'h0;  // S1P1.
	localparam logic [3:0] POS_S3P1 = 4'h4;  // S3P1, shift clock falls.
	localparam logic [3:0] POS_S5P2 = 4'h9;  // S5P2, data pin sampled.
	localparam logic [3:0] POS_S6P2 = 4'hB;  // S6P2, shift edge.
	localparam logic [3:0] POS_LAST = 4'hB;  // Last position of a cycle.

	// ==========================================================
	// Divide-by-16 bit counter.
	localparam logic [3:0] DIV_LAST  = 4'hF;  // Rollover state.
	localparam logic [3:0] SMP_FIRST = 4'h7;  // First of three sample states.
	localparam int         SMP_COUNT = 3;     // Samples per bit time.
endpackage
`default_nettype wire

// ---- ume_mcycle.sv ----
// Machine cycle sequencer: twelve clock positions, S1P1 through S6P2.
`timescale 1ns/100ps
`default_nettype none
module ume_mcycle
	import ume_pkg::*;
(
	input  wire logic       i_clk,  // CPU clock.
	input  wire logic       i_rst,  // Synchronous reset, active high.
	output var  logic [3:0] o_pos   // Current state and phase position.
);
	// ==========================================================
	// Position counter.

	// Walks S1P1..S6P2 and wraps; the engine reads all mode 0 timing and the mode 1 send start from it.
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_pos <= POS_S1P1;
		end else if (o_pos == POS_LAST) begin
			o_pos <= POS_S1P1;
		end else begin
			o_pos <= o_pos + 4'h1;
		end
	end

	// The position must never leave the twelve legal values.
	pos_range_a: assert property (@(posedge i_clk) disable iff (i_rst) o_pos <= POS_LAST)
		else $error("machine cycle position out of range");
endmodule
`default_nettype wire

// ---- ume_peer.sv ----
// Far-side model: an external shift register for mode 0 and a serial peer for mode 1.
`timescale 1ns/100ps
`default_nettype none
module ume_peer #(
	parameter int BIT = 16  // Clocks per mode 1 bit time.
) (
	input  wire logic clk,      // Board clock, used only to time bits.
	input  wire logic txd,      // Shift clock or frame from the device.
	input  wire logic rxd_out,  // Value the device drives on the data pin.
	input  wire logic rxd_oe,   // High while the device drives the data pin.
	output var  logic rxd_line  // Resolved level of the data pin.
);
	// ==========================================================
	// Pin resolution and capture state.
	logic       drv = 1'b1;  // Own drive; the line idles high in mode 1.
	logic       m0 = 1'b0;   // Mode 0 offering is under way.
	logic [7:0] cap = 8'h00; // Bits taken from mode 0 sends.
	logic [7:0] src = 8'h00; // Byte offered to a mode 0 receive.
	int         left = 0;    // Mode 0 bits still to offer.
	int         rise_n = 0;  // Shift clock rises while the device drives.
	int         rise_dt = 0; // Spacing of the last two rises, in ns.
	time        rise_t = 0;  // Time of the latest rise.
	assign rxd_line = rxd_oe ? rxd_out : drv;
	// Take data on the shift clock rise; the device moves it three clocks later.
	always @(posedge txd) begin
		if (rxd_oe) begin
			cap <= {rxd_out, cap[7:1]};
			rise_n <= rise_n + 1;
			rise_dt <= int'($time - rise_t);
			rise_t <= $time;
		end
	end
	// Offer a new bit on each fall, so it is settled when the device samples.
	always @(negedge txd) begin
		if (m0 && left > 0) begin
			drv <= src[8 - left];
			left <= left - 1;
		end else if (m0) begin
			drv <= ~drv; // Toggled: the pin flips on each later fall.
		end
	end
	task automatic m0_offer(input logic [7:0] b);
		src = b;
		left = 8;
		m0 = 1'b1;
	endtask
	task automatic m0_end();
		m0 = 1'b0;
		drv <= 1'b1;
	endtask
	// Send one frame; a glitch is a short low that must be rejected.
	task automatic m1_send(input logic [7:0] b, input logic stop, input logic glitch);
		logic [9:0] f;
		f = {stop, b, 1'b0};
		for (int i = 0; i < (glitch ? 1 : 10); i++) begin
			@(posedge clk);
			drv <= f[i];
			repeat (glitch ? 2 : BIT - 1) @(posedge clk);
		end
		@(posedge clk);
		drv <= 1'b1;
		repeat (BIT * 2) @(posedge clk);
	endtask
	// The start bit may be cut short, so each bit is read just after its start.
	task automatic m1_get(output logic [7:0] b, output logic stop, output logic ok);
		int n;
		n = 0;
		while (txd !== 1'b0 && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		ok = (n < 4000);
		for (int k = 1; k <= 9; k++) begin
			repeat (k == 1 ? BIT + 2 : BIT) @(posedge clk);
			#1;
			if (k < 9) b[k - 1] = txd;
			else stop = txd;
		end
	endtask
endmodule
`default_nettype wire

// ---- ume_engine_tb_top.sv ----
// Self-checking bench for the mode 0 / mode 1 serial engine.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
	$display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module ume_engine_tb_top;
	import ume_pkg::*;
	// ==========================================================
	// Stimulus and observed signals.
	logic       clk = 1'b0;    // 20 MHz CPU clock.
	logic       rst = 1'b1;    // Synchronous reset.
	logic       wr = 1'b0;     // Write strobe.
	logic       rd = 1'b0;     // Read strobe.
	logic       ovf = 1'b0;    // Timer overflow, one pulse every clock.
	logic [1:0] addr = 2'h0;   // Register address.
	logic [7:0] wdata = 8'h00; // Write data.
	logic [7:0] rdata;         // Read data.
	logic       rxd_line, rxd_out, rxd_oe, txd, sint;
	logic [7:0] b;             // Byte taken by the peer.
	logic       s, ok;         // Stop bit and found flag from the peer.
	int         error_cnt = 0;
	int         comparisons = 0;
	always #25 clk = ~clk;
	// Overflow every clock with doubling on gives 16 clocks a bit.
	always @(posedge clk) ovf <= !rst;
	ume_engine u_dut (
		.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
		.O_RDATA(rdata), .I_T1_OVF(ovf), .I_RXD(rxd_line), .O_RXD(rxd_out),
		.O_RXD_OE(rxd_oe), .O_TXD(txd), .O_SINT(sint)
	);
	ume_peer #(.BIT(16)) u_peer (
		.clk(clk), .txd(txd), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_line(rxd_line)
	);
	// ==========================================================
	// Bus cycles; each waits an edge first so strobes never collide.
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic check_reg(input logic [1:0] a, input logic [7:0] e);
		logic [7:0] d;
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		`CHK(d, e)
	endtask
	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded wait for the interrupt request that follows a done flag.
	task automatic wait_sint(input int lim);
		int n;
		n = 0;
		while (sint !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= lim) begin
			error_cnt++;
			$display("mismatch at %0t: done flag never came", $time);
			report_and_stop();
		end
	endtask
	// ==========================================================
	// Scenarios.
	task automatic t_reset();
		`CHK(txd, 1'b1)
		check_reg(REG_CTRL, 8'h00);
		check_reg(REG_PWR, 8'h00);
		wr_reg(2'h3, 8'hFF);
		check_reg(2'h3, 8'h00);
	endtask
	// Mode 0 send; the flag must not come early and the clock runs at clk/12.
	task automatic t_m0_tx();
		wr_reg(REG_BUF, 8'hA5);
		repeat (90) @(posedge clk);
		#1 `CHK(sint, 1'b0)
		wait_sint(60);
		`CHK(u_peer.cap, 8'hA5)
		`CHK(u_peer.rise_n, 8)
		`CHK(u_peer.rise_dt, 600)
		`CHK(rxd_oe, 1'b0)
		check_reg(REG_CTRL, 8'h02);
		wr_reg(REG_CTRL, 8'h00);
		check_reg(REG_CTRL, 8'h00);
		`CHK(sint, 1'b0)
	endtask
	task automatic t_m0_rx();
		u_peer.m0_offer(8'h3C);
		wr_reg(REG_CTRL, 8'h10);
		wait_sint(200);
		check_reg(REG_BUF, 8'h3C);
		check_reg(REG_CTRL, 8'h11);
		wr_reg(REG_CTRL, 8'h00);
		u_peer.m0_end();
	endtask
	// Mode 1 send; a second write while busy must be ignored.
	task automatic t_m1_tx();
		wr_reg(REG_PWR, 8'h80);
		check_reg(REG_PWR, 8'h80);
		wr_reg(REG_CTRL, 8'h40);
		wr_reg(REG_BUF, 8'h96);
		wr_reg(REG_BUF, 8'hFF);
		u_peer.m1_get(b, s, ok);
		`CHK(ok, 1'b1)
		`CHK(b, 8'h96)
		`CHK(s, 1'b1)
		wait_sint(40);
		check_reg(REG_CTRL, 8'h42);
	endtask
	task automatic t_m1_rx();
		wr_reg(REG_CTRL, 8'h50);
		u_peer.m1_send(8'h5A, 1'b1, 1'b0);
		`CHK(sint, 1'b1)
		check_reg(REG_BUF, 8'h5A);
		check_reg(REG_CTRL, 8'h55);
		u_peer.m1_send(8'hC3, 1'b1, 1'b0);
		check_reg(REG_BUF, 8'h5A);
		wr_reg(REG_CTRL, 8'h50);
		u_peer.m1_send(8'h00, 1'b0, 1'b1);
		u_peer.m1_send(8'h33, 1'b1, 1'b0);
		check_reg(REG_BUF, 8'h33);
		wr_reg(REG_CTRL, 8'h70);
		u_peer.m1_send(8'h0F, 1'b0, 1'b0);
		check_reg(REG_CTRL, 8'h74);
		check_reg(REG_BUF, 8'h33);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_reset();
		t_m0_tx();
		t_m0_rx();
		t_m1_tx();
		t_m1_rx();
		report_and_stop();
	end
endmodule
`default_nettype wire
